//--- buffer_field_map.svh
`ifndef BUFFER_FIELD_MAP_SVH
`define BUFFER_FIELD_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_HEADER 4'h0
`define ADDR_PAYLOAD 4'h1
`define ADDR_SLOT_STATUS 4'h2
`define ADDR_CTRL_STATUS 4'h3
`define ADDR_CYCLE_FILTER 4'h4
`define ADDR_SETUP 4'h5

// ----------------------------------------------------------------------------
// Header word fields
// ----------------------------------------------------------------------------
`define HDR_RESERVED 31
`define HDR_PREAMBLE 30
`define HDR_NULL_FRAME 29
`define HDR_SYNC 28
`define HDR_STARTUP 27
`define HDR_ID_LSB 16
`define HDR_ID_MSB 26
`define HDR_LEN_LSB 9
`define HDR_LEN_MSB 15
`define HDR_CRC_LSB 0
`define HDR_CRC_MSB 8

// ----------------------------------------------------------------------------
// Control and status word fields
// ----------------------------------------------------------------------------
`define CS_CFG 0
`define CS_IRQ_FLAG 1
`define CS_IRQ_ENABLE 2
`define CS_LOCK 3
`define CS_COMMIT 4
`define CS_CH_ONE 5
`define CS_CH_TWO 6
`define CS_DATA_UPD 7
`define CS_KIND 8
`define CS_CYC_FILT_EN 9
`define CS_TX_TYPE 10
`define CS_VALID 11
`define CS_CYCLE_LSB 16
`define CS_CYCLE_MSB 21

// ----------------------------------------------------------------------------
// Setup word fields and reset values
// ----------------------------------------------------------------------------
`define SETUP_CONFIG 0
`define SETUP_TYPE_LSB 1
`define SETUP_TYPE_MSB 3
`define RESET_WORD 32'h0000_0000
`define RESET_SETUP 32'h0000_0001

`endif

//--- buffer_field_pkg.sv
package buffer_field_pkg;

  // Buffer kinds as seen from the host.
  typedef enum logic [2:0] {
    BUF_RECEIVE = 3'h0,
    BUF_FIFO = 3'h1,
    BUF_TX_STATIC = 3'h2,
    BUF_TX_DYNAMIC = 3'h3,
    BUF_TX_DOUBLE_HOST = 3'h4,
    BUF_TX_DOUBLE_CC = 3'h5
  } buf_kind_t;

  // Host access permission of one field.
  typedef enum logic [1:0] {
    ACC_RO = 2'h0,
    ACC_WR = 2'h1,
    ACC_CFG = 2'h2,
    ACC_NU = 2'h3
  } access_t;

  // Host register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } host_req_t;

  // Controller-side updates of status fields.
  typedef struct packed {
    logic [31:0] header;
    logic [31:0] slotStatus;
    logic [5:0] cycle;
    logic headerLoad;
    logic slotLoad;
    logic irqSet;
    logic validSet;
    logic dataUpdSet;
    logic commitClear;
  } cc_update_t;

endpackage

//--- buffer_field_access_guard.sv
`include "buffer_field_map.svh"
`timescale 1ns/1ns
`default_nettype none

module buffer_field_access_guard (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Host register port.
  input wire buffer_field_pkg::host_req_t hostReq,
  output logic [31:0] rdata,
  // Controller side.
  input wire buffer_field_pkg::cc_update_t ccUpdate,
  input wire logic lockGrant,
  output logic lockRequest,
  output logic configState,
  output logic [2:0] bufferKind
);

  // ----------------------------------------------------------------------------
  // Access decoding
  // ----------------------------------------------------------------------------

  // Header field permission: sel 0 reserved/preamble, 1 id/len/crc, 2 status bits.
  function automatic buffer_field_pkg::access_t hdrAccess(input logic [2:0] kind,
                                                          input logic [1:0] sel);
    buffer_field_pkg::access_t acc;
    acc = buffer_field_pkg::ACC_RO;
    unique case (kind)
      buffer_field_pkg::BUF_RECEIVE:
        acc = (sel == 2'h1) ? buffer_field_pkg::ACC_CFG : buffer_field_pkg::ACC_RO;
      buffer_field_pkg::BUF_TX_DYNAMIC: begin
        acc = (sel == 2'h2) ? buffer_field_pkg::ACC_NU : buffer_field_pkg::ACC_WR;
      end
      buffer_field_pkg::BUF_TX_STATIC, buffer_field_pkg::BUF_TX_DOUBLE_HOST: begin
        acc = (sel == 2'h2) ? buffer_field_pkg::ACC_NU : buffer_field_pkg::ACC_CFG;
      end
      default: acc = buffer_field_pkg::ACC_RO;
    endcase
    return acc;
  endfunction

  // True when a field of the given permission takes a host write now.
  function automatic logic canWrite(input buffer_field_pkg::access_t acc, input logic cfg);
    return (acc == buffer_field_pkg::ACC_WR) ||
           ((acc == buffer_field_pkg::ACC_CFG) && cfg);
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic [31:0] header, next_header;
  logic [31:0] payload, next_payload;
  logic [31:0] slotStatus, next_slotStatus;
  logic [31:0] ctrl, next_ctrl;
  logic [11:0] filter, next_filter;
  logic [31:0] setup, next_setup;
  logic [31:0] next_rdata;

  logic [2:0] kind;
  logic cfg;
  logic isRx, isFifo, isTx, isCc;
  logic wrHdr, wrPay, wrCs, wrCf, wrSetup;
  buffer_field_pkg::access_t accA, accB;
  logic cfgWr;

  assign kind = setup[`SETUP_TYPE_MSB:`SETUP_TYPE_LSB];
  assign cfg = setup[`SETUP_CONFIG];
  assign isRx = (kind == buffer_field_pkg::BUF_RECEIVE);
  assign isFifo = (kind == buffer_field_pkg::BUF_FIFO);
  assign isCc = (kind == buffer_field_pkg::BUF_TX_DOUBLE_CC);
  assign isTx = !isRx && !isFifo;
  assign accA = hdrAccess(kind, 2'h0);
  assign accB = hdrAccess(kind, 2'h1);
  assign cfgWr = cfg && !isFifo && !isCc;
  assign wrHdr = hostReq.wr && (hostReq.addr == `ADDR_HEADER);
  assign wrPay = hostReq.wr && (hostReq.addr == `ADDR_PAYLOAD);
  assign wrCs = hostReq.wr && (hostReq.addr == `ADDR_CTRL_STATUS);
  assign wrCf = hostReq.wr && (hostReq.addr == `ADDR_CYCLE_FILTER);
  assign wrSetup = hostReq.wr && (hostReq.addr == `ADDR_SETUP);

  // Next-value computation for the buffer fields.
  always_comb begin
    next_header = header;
    next_payload = payload;
    next_slotStatus = slotStatus;
    next_ctrl = ctrl;
    next_filter = filter;
    next_setup = setup;
    // Controller updates of header, cycle, slot status and control status bits.
    if (ccUpdate.headerLoad && !isTx) begin
      next_header = ccUpdate.header;
      next_ctrl[`CS_CYCLE_MSB:`CS_CYCLE_LSB] = ccUpdate.cycle;
    end
    if (ccUpdate.slotLoad) begin
      next_slotStatus = ccUpdate.slotStatus;
    end
    if (ccUpdate.irqSet && !isFifo) begin
      next_ctrl[`CS_IRQ_FLAG] = 1'b1;
    end
    if (ccUpdate.validSet && !isFifo) begin
      next_ctrl[`CS_VALID] = 1'b1;
    end
    if (ccUpdate.commitClear) begin
      next_ctrl[`CS_COMMIT] = 1'b0;
    end
    // Host header writes, field by field; refused fields stay put.
    if (wrHdr) begin
      if (canWrite(accA, cfg)) begin
        next_header[`HDR_RESERVED] = hostReq.wdata[`HDR_RESERVED];
        next_header[`HDR_PREAMBLE] = hostReq.wdata[`HDR_PREAMBLE];
      end
      // A receive buffer takes only its frame ID; length and CRC stay read-only there.
      if (canWrite(accB, cfg)) begin
        if (isRx) begin
          next_header[`HDR_ID_MSB:`HDR_ID_LSB] = hostReq.wdata[`HDR_ID_MSB:`HDR_ID_LSB];
        end else begin
          next_header[`HDR_ID_MSB:`HDR_CRC_LSB] = hostReq.wdata[`HDR_ID_MSB:`HDR_CRC_LSB];
        end
      end
    end
    if (wrPay && isTx && !isCc) begin
      next_payload = hostReq.wdata;
    end
    // Host control writes.
    if (wrCs && !isCc) begin
      if (!isFifo) begin
        next_ctrl[`CS_IRQ_ENABLE] = hostReq.wdata[`CS_IRQ_ENABLE];
      end
      if (isTx) begin
        next_ctrl[`CS_COMMIT] = hostReq.wdata[`CS_COMMIT];
      end
      if (cfgWr) begin
        next_ctrl[`CS_CFG] = hostReq.wdata[`CS_CFG];
        next_ctrl[`CS_CH_ONE] = hostReq.wdata[`CS_CH_ONE];
        next_ctrl[`CS_CH_TWO] = hostReq.wdata[`CS_CH_TWO];
        next_ctrl[`CS_CYC_FILT_EN] = hostReq.wdata[`CS_CYC_FILT_EN];
        next_ctrl[`CS_KIND] = isTx & hostReq.wdata[`CS_KIND];
        if (isRx) begin
          next_ctrl[`CS_VALID] = hostReq.wdata[`CS_VALID];
        end
      end
      if ((cfgWr && isTx) || (kind == buffer_field_pkg::BUF_TX_DYNAMIC)) begin
        next_ctrl[`CS_TX_TYPE] = hostReq.wdata[`CS_TX_TYPE];
      end
    end else if (ccUpdate.dataUpdSet && isRx) begin
      next_ctrl[`CS_DATA_UPD] = 1'b1;
    end
    if (wrCs && cfgWr && isRx) begin
      next_ctrl[`CS_DATA_UPD] = hostReq.wdata[`CS_DATA_UPD] | ccUpdate.dataUpdSet;
    end
    if (wrCf && cfgWr) begin
      next_filter = hostReq.wdata[11:0];
    end
    if (wrSetup) begin
      next_setup = {28'h0000000, hostReq.wdata[`SETUP_TYPE_MSB:`SETUP_CONFIG]};
    end
  end

  // Read data with unused fields forced to zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hostReq.rd) begin
      unique case (hostReq.addr)
        `ADDR_HEADER: begin
          if (!isCc) begin
            next_rdata = header;
            if (isTx) begin
              next_rdata[`HDR_NULL_FRAME] = 1'b0;
              next_rdata[`HDR_SYNC] = 1'b0;
              next_rdata[`HDR_STARTUP] = 1'b0;
            end
          end
        end
        `ADDR_PAYLOAD: next_rdata = isCc ? 32'h0000_0000 : payload;
        `ADDR_SLOT_STATUS: next_rdata = isCc ? 32'h0000_0000 : slotStatus;
        `ADDR_CTRL_STATUS: begin
          next_rdata = ctrl;
          next_rdata[`CS_LOCK] = lockGrant && !isCc;
          if (isTx) begin
            next_rdata[`CS_CYCLE_MSB:`CS_CYCLE_LSB] = 6'h00;
            next_rdata[`CS_DATA_UPD] = 1'b0;
          end
          if (isRx) begin
            next_rdata[`CS_COMMIT] = 1'b0;
            next_rdata[`CS_KIND] = 1'b0;
          end
          if (isFifo) begin
            next_rdata = 32'h0000_0000;
            next_rdata[`CS_LOCK] = lockGrant;
          end
        end
        `ADDR_CYCLE_FILTER: next_rdata = isFifo ? 32'h0000_0000 : {20'h00000, filter};
        `ADDR_SETUP: next_rdata = setup;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      header <= `RESET_WORD;
      payload <= `RESET_WORD;
      slotStatus <= `RESET_WORD;
      ctrl <= `RESET_WORD;
      filter <= 12'h000;
      setup <= `RESET_SETUP;
      rdata <= `RESET_WORD;
    end else if (clkEn) begin
      header <= next_header;
      payload <= next_payload;
      slotStatus <= next_slotStatus;
      ctrl <= next_ctrl;
      filter <= next_filter;
      setup <= next_setup;
      rdata <= next_rdata;
    end
  end

  // The request pulse follows the lock bit of the write itself, in the write's own cycle.
  assign lockRequest = clkEn && wrCs && !isCc && hostReq.wdata[`CS_LOCK];
  assign configState = cfg;
  assign bufferKind = kind;

endmodule

`default_nettype wire

//--- buffer_field_access_guard_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module access_guard_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Watched ports.
  input wire buffer_field_pkg::host_req_t hostReq,
  input wire logic [31:0] rdata,
  input wire logic lockGrant,
  input wire logic lockRequest,
  input wire logic [2:0] bufferKind
);
  // --------------------------------------------------------------------------
  // Port checks
  // --------------------------------------------------------------------------
  // Reads qualified by the register they address.
  logic rdHdr, rdCtl, rdFilt, txKind;
  assign rdHdr = clkEn && hostReq.rd && hostReq.addr == 4'h0;
  assign rdCtl = clkEn && hostReq.rd && hostReq.addr == 4'h3;
  assign rdFilt = clkEn && hostReq.rd && hostReq.addr == 4'h4;
  assign txKind = bufferKind >= 3'h2 && bufferKind <= 3'h4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_lock_req;
    lockRequest == (clkEn && hostReq.wr && hostReq.addr == 4'h3 && hostReq.wdata[3]
      && bufferKind != 3'h5);
  endproperty
  a_lock_req: assert property (p_lock_req) else $error("lock request wrong");
  property p_cc_never;
    bufferKind == 3'h5 |-> !lockRequest;
  endproperty
  a_cc_never: assert property (p_cc_never) else $error("lock asked for cc half");
  property p_lock_read;
    rdCtl && bufferKind != 3'h5 |=> rdata[3] == $past(lockGrant);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock readback wrong");
  property p_cc_lock;
    rdCtl && bufferKind == 3'h5 |=> !rdata[3];
  endproperty
  a_cc_lock: assert property (p_cc_lock) else $error("cc half shows lock");
  property p_tx_hdr;
    rdHdr && txKind |=> rdata[29:27] == 3'h0;
  endproperty
  a_tx_hdr: assert property (p_tx_hdr) else $error("tx header unused set");
  property p_tx_ctl;
    rdCtl && txKind |=> !rdata[7] && rdata[21:16] == 6'h00;
  endproperty
  a_tx_ctl: assert property (p_tx_ctl) else $error("tx control unused set");
  property p_rx_ctl;
    rdCtl && bufferKind == 3'h0 |=> !rdata[4] && !rdata[8] && !rdata[10];
  endproperty
  a_rx_ctl: assert property (p_rx_ctl) else $error("rx control unused set");
  property p_fifo_ctl;
    rdCtl && bufferKind == 3'h1 |=> (rdata & 32'hffff_fff7) == 32'h0;
  endproperty
  a_fifo_ctl: assert property (p_fifo_ctl) else $error("fifo control set");
  property p_fifo_filt;
    rdFilt && bufferKind == 3'h1 |=> rdata == 32'h0;
  endproperty
  a_fifo_filt: assert property (p_fifo_filt) else $error("fifo filter set");
  // Main scenarios.
  c_lock: cover property (lockRequest);
  c_fifo: cover property (rdCtl && bufferKind == 3'h1);
  c_dyn: cover property (rdHdr && bufferKind == 3'h3);
endmodule

bind buffer_field_access_guard access_guard_checker u_access_guard_checker (.clk(clk),
  .rst_b(rst_b), .clkEn(clkEn), .hostReq(hostReq), .rdata(rdata), .lockGrant(lockGrant),
  .lockRequest(lockRequest), .bufferKind(bufferKind));

`default_nettype wire

//--- cc_lock_partner.sv
`timescale 1ns/1ns
`default_nettype none

module cc_lock_partner (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Lock handshake.
  input wire logic lockRequest,
  input wire logic slow,
  input wire logic [2:0] kind,
  output logic lockGrant
);
  // --------------------------------------------------------------------------
  // Grant logic
  // --------------------------------------------------------------------------
  // Lock grants after a delay, unlock at once; the cc half is never granted.
  logic pending;
  logic [2:0] delayCnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lockGrant <= 1'b0;
      pending <= 1'b0;
      delayCnt <= 3'h0;
    end else if (lockRequest && kind != 3'h5) begin
      lockGrant <= 1'b0;
      pending <= !lockGrant;
      delayCnt <= slow ? 3'h4 : 3'h0;
    end else if (pending && delayCnt == 3'h0) begin
      pending <= 1'b0;
      lockGrant <= 1'b1;
    end else if (pending) begin
      delayCnt <= delayCnt - 3'h1;
    end
  end
endmodule

`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module testbench;
  // --------------------------------------------------------------------------
  // Bench
  // --------------------------------------------------------------------------
  logic clk, rst_b, lockGrant, lockRequest, configState, slow, clkEn;
  logic [2:0] bufferKind;
  logic [31:0] rdata;
  buffer_field_pkg::host_req_t hostReq;
  buffer_field_pkg::cc_update_t ccUpdate;
  int err_total, compares;
  buffer_field_access_guard u_buffer_field_access_guard (.clk(clk), .rst_b(rst_b),
    .clkEn(clkEn), .hostReq(hostReq), .rdata(rdata), .ccUpdate(ccUpdate),
    .lockGrant(lockGrant), .lockRequest(lockRequest), .configState(configState),
    .bufferKind(bufferKind));
  cc_lock_partner u_cc_lock_partner (.clk(clk), .rst_b(rst_b), .lockRequest(lockRequest),
    .slow(slow), .kind(bufferKind), .lockGrant(lockGrant));
  // Clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Host bus cycles and reset.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    hostReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    hostReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    hostReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    hostReq.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic reset();
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
  // Receive, transmit, fifo and cc half sequences.
  initial begin
    rst_b = 1'b0;
    hostReq = '0;
    ccUpdate = '0;
    clkEn = 1'b1;
    slow = 1'b1;
    reset();
    rd(4'h5, 32'h0000_0001);
    wr(4'h0, 32'hffff_ffff);
    wr(4'h3, 32'h0000_0fff);
    rd(4'h3, 32'h0000_0ae5);
    rd(4'h0, 32'h07ff_0000);
    wr(4'h4, 32'h0000_0fff);
    rd(4'h4, 32'h0000_0fff);
    rd(4'h3, 32'h0000_0aed);
    wr(4'h5, 32'h0);
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h0);
    wr(4'h3, 32'h0);
    wr(4'h1, 32'h1234_5678);
    rd(4'h0, 32'h07ff_0000);
    rd(4'h4, 32'h0000_0fff);
    rd(4'h3, 32'h0000_0ae9);
    rd(4'h1, 32'h0);
    // Controller raises the interrupt flag; it reads back beside the host fields.
    @(posedge clk);
    ccUpdate.irqSet <= 1'b1;
    @(posedge clk);
    ccUpdate.irqSet <= 1'b0;
    rd(4'h3, 32'h0000_0aeb);
    // A write while the clock enable is low must leave the setup word alone.
    @(posedge clk);
    clkEn <= 1'b0;
    wr(4'h5, 32'h0000_0005);
    clkEn <= 1'b1;
    rd(4'h5, 32'h0000_0000);
    `CHK(configState, 1'b0)
    `CHK(bufferKind, 3'h0)
    slow <= 1'b0;
    for (int k = 2; k < 5; k++) begin
      reset();
      wr(4'h5, {28'h0, k[2:0], 1'b1});
      #1;
      `CHK(configState, 1'b1)
      `CHK(bufferKind, k[2:0])
      wr(4'h0, 32'hffff_ffff);
      rd(4'h0, 32'hc7ff_ffff);
      wr(4'h5, {28'h0, k[2:0], 1'b0});
      wr(4'h0, 32'h0);
      rd(4'h0, k == 3 ? 32'h0 : 32'hc7ff_ffff);
      wr(4'h1, 32'h5a5a_a5a5);
      rd(4'h1, 32'h5a5a_a5a5);
      wr(4'h3, 32'h003f_0494);
      rd(4'h3, k == 3 ? 32'h0000_0414 : 32'h0000_0014);
    end
    reset();
    wr(4'h5, 32'h0000_0003);
    wr(4'h0, 32'hffff_ffff);
    wr(4'h3, 32'h0000_0fff);
    rd(4'h3, 32'h0000_0008);
    rd(4'h0, 32'h0);
    wr(4'h4, 32'h0000_0fff);
    rd(4'h4, 32'h0);
    reset();
    wr(4'h5, 32'h0000_000b);
    wr(4'h3, 32'h0000_0fff);
    wr(4'h4, 32'h0000_0fff);
    rd(4'h3, 32'h0);
    rd(4'h4, 32'h0);
    summarize();
  end
endmodule

`default_nettype wire
